// [vmrc_pkg.sv]
// Package of constants and types for the voltage monitor controller
package vmrc_pkg;

	// ==================================================================
	// Geometry
	localparam int          VMRC_MONITORS     = 3;
	localparam int          VMRC_DIV_W        = 3;
	localparam int          VMRC_SETTLE_W     = 16;

	// ==================================================================
	// Timing
	// Detector settle delay in nanoseconds, and clock period
	localparam int          VMRC_SETTLE_NS    = 100000;
	localparam int          VMRC_CLK_NS       = 10;
	localparam int          VMRC_SETTLE_CYC   =
		(VMRC_SETTLE_NS + VMRC_CLK_NS - 1) / VMRC_CLK_NS;
	// Identical samples needed before a level change is accepted
	localparam logic [1:0]  VMRC_FILT_SAMPLES = 2'h3;

	// ==================================================================
	// Sampling clock divide codes
	localparam logic [1:0]  VMRC_DIV1         = 2'h0;
	localparam logic [1:0]  VMRC_DIV2         = 2'h1;
	localparam logic [1:0]  VMRC_DIV4         = 2'h2;
	localparam logic [1:0]  VMRC_DIV8         = 2'h3;

	// ==================================================================
	// Reset values
	localparam logic        VMRC_FLAG_RST     = 1'h0;
	localparam logic        VMRC_LEVEL_RST    = 1'h1;

	// Per monitor detector state
	typedef enum logic [1:0] {
		VMRC_OFF,
		VMRC_SETTLE,
		VMRC_ACTIVE
	} vmrc_phase_type;

endpackage

// [vmrc_monitor.sv]
// One voltage monitor channel: settle, filter, crossing flag, action
`timescale 1ns/1ps
module vmrc_monitor (
	// Clock and resets
	input  wire logic                          sys_clk,
	input  wire logic                          srst,
	input  wire logic                          flag_rst,
	// Control
	input  wire logic                          detector_on,
	input  wire logic                          action_en,
	input  wire logic                          filter_bypass,
	input  wire logic                          action_sel,
	input  wire logic                          edge_sel,
	input  wire logic [1:0]                    sample_div,
	input  wire logic                          flag_clear,
	input  wire logic                          irq_capable,
	input  wire logic [vmrc_pkg::VMRC_SETTLE_W-1:0] settle_cycles,
	// Sampling time base
	input  wire logic                          slow_osc_tick,
	input  wire logic                          slow_osc_run,
	// Comparator
	input  wire logic                          comparator,
	// Results
	output logic                               cross_flag,
	output logic                               level,
	output logic                               irq,
	output logic                               rst_req
);
	import vmrc_pkg::*;

	typedef struct packed {
		vmrc_phase_type             phase;
		logic [VMRC_SETTLE_W-1:0]   settle;
		logic [VMRC_DIV_W-1:0]      div;
		logic [1:0]                 same;
		logic                       level;
		logic                       flag;
		logic                       irq;
		logic                       rst_req;
	} vmrc_mon_type;

	vmrc_mon_type state;
	vmrc_mon_type next_state;
	logic         sample_en;
	logic         changed;
	logic         hit;

	// ==================================================================
	// Sampling enable: slow oscillator tick divided by 1, 2, 4 or 8
	always_comb begin
		unique case (sample_div) // RQ14
			VMRC_DIV1: sample_en = slow_osc_tick;
			VMRC_DIV2: sample_en = slow_osc_tick && state.div[0] == 1'b1;
			VMRC_DIV4: sample_en = slow_osc_tick && state.div[1:0] == 2'h3;
			VMRC_DIV8: sample_en = slow_osc_tick && state.div == 3'h7;
		endcase
	end

	// ==================================================================
	// Next state
	always_comb begin
		next_state = state;
		changed = 1'b0;
		next_state.irq = 1'b0;
		if (slow_osc_tick)
			next_state.div = state.div + 3'h1;
		unique case (state.phase)
			VMRC_OFF: begin
				next_state.level = VMRC_LEVEL_RST;
				if (detector_on) begin
					next_state.phase = VMRC_SETTLE;
					next_state.settle = settle_cycles; // RQ18
				end
			end
			VMRC_SETTLE: begin
				// Comparator loads level but flags no crossing while the detector settles
				if (state.settle == '0)
					next_state.phase = VMRC_ACTIVE; // RQ18
				else
					next_state.settle = state.settle - 1'b1;
				next_state.level = comparator;
			end
			VMRC_ACTIVE: begin
				if (filter_bypass) begin // RQ3 RQ10
					next_state.same = 2'h0;
					changed = comparator != state.level;
					next_state.level = comparator;
				end else if (sample_en && slow_osc_run) begin // RQ3
					if (comparator == state.level) begin
						next_state.same = 2'h0;
					end else if (state.same + 2'h1 == VMRC_FILT_SAMPLES) begin
						next_state.same = 2'h0; // RQ17
						changed = 1'b1;
						next_state.level = comparator;
					end else begin
						next_state.same = state.same + 2'h1;
					end
				end
			end
		endcase
		if (!detector_on)
			next_state.phase = VMRC_OFF;
		// Filtered mode flags both directions; bypass obeys edge select
		hit = changed && (!filter_bypass ||
			(edge_sel ? !comparator : comparator)); // RQ12
		if (flag_clear)
			next_state.flag = 1'b0; // RQ15
		if (hit)
			next_state.flag = 1'b1; // RQ15
		if (hit && action_en) begin // RQ8
			if (action_sel || !irq_capable) // RQ4 RQ13
				next_state.rst_req = 1'b1;
			else
				next_state.irq = 1'b1;
		end
	end

	// ==================================================================
	// Registers; flag survives internal resets, cleared only by flag_rst or flag_clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state.phase <= VMRC_OFF;
			state.settle <= '0;
			state.div <= '0;
			state.same <= 2'h0;
			state.level <= VMRC_LEVEL_RST;
			state.irq <= 1'b0;
			state.rst_req <= 1'b0;
		end else begin
			state.phase <= next_state.phase;
			state.settle <= next_state.settle;
			state.div <= next_state.div;
			state.same <= next_state.same;
			state.level <= next_state.level;
			state.irq <= next_state.irq;
			state.rst_req <= next_state.rst_req;
		end
		if (flag_rst)
			state.flag <= VMRC_FLAG_RST; // RQ16
		else
			state.flag <= next_state.flag;
	end

	assign cross_flag = state.flag;
	assign level = state.level;
	assign irq = state.irq;
	assign rst_req = state.rst_req;
endmodule

// [vmrc_ctrl.sv]
// Three-channel voltage monitor interrupt and reset controller top
// Operation
// RQ1 - Software enables detector, then waits settle delay before other settings.
// RQ2 - Software selects sampling divide before enabling filter.
// RQ3 - Filter bypass 0 filters comparator; 1 uses comparator directly.
// RQ4 - Action select 0 interrupt, 1 reset; monitor 0 always reset.
// RQ5 - Software clears crossing flag before enabling monitor.
// RQ6 - Software starts slow oscillator when the filter is used.
// RQ7 - Filtered use waits four sampling clocks before enabling.
// RQ8 - Action enable set last; only then interrupt or reset fires.
// RQ9 - Divide, bypass and action select may be written together atomically.
// RQ10 - Stop-mode wake needs filter bypass; no sampling clock then.
// RQ11 - Reset mode needs edge select 1 (falling crossing).
// RQ12 - Bypass mode edge select picks rising or falling crossing.
// RQ13 - Monitors 1, 2 interrupt or reset; monitor 0, reduced 1 reset only.
// RQ14 - Sampling divide codes 0..3 divide slow clock by 1, 2, 4, 8.
// RQ15 - Flag set by hardware, cleared only by writing 0.
// RQ16 - Flags survive software, watchdog and monitor resets.
// RQ17 - Filtered change accepted after identical consecutive samples.
// RQ18 - Settle counter after detector enable ignores comparator.
`timescale 1ns/1ps
module vmrc_ctrl #(
	parameter logic [vmrc_pkg::VMRC_SETTLE_W-1:0] SETTLE_CYCLES =
		vmrc_pkg::VMRC_SETTLE_W'(vmrc_pkg::VMRC_SETTLE_CYC),
	parameter bit  REDUCED_MON1 = 1'b0
) (
	// Clock and resets
	input  wire logic                      sys_clk,
	input  wire logic                      srst,
	input  wire logic                      flag_rst,
	// Detector enables
	input  wire logic [2:0]                detector_on,
	// Monitor control, bit i for monitor i; sample_div bits 2i+1:2i for monitor i
	input  wire logic [2:0]                action_en,
	input  wire logic [2:0]                filter_bypass,
	input  wire logic [2:0]                action_sel,
	input  wire logic [2:0]                edge_sel,
	input  wire logic [5:0]                sample_div,
	input  wire logic [2:0]                flag_clear,
	// Slow oscillator
	input  wire logic                      slow_osc_clock,
	input  wire logic                      slow_osc_stop,
	// Comparators
	input  wire logic [2:0]                comparator,
	// Status and actions
	output logic [2:0]                     cross_flag,
	output logic [2:0]                     level,
	output logic [2:0]                     irq,
	output logic                           reset_out
);
	import vmrc_pkg::*;

	typedef struct packed {
		logic osc_prev;
		logic tick;
	} vmrc_top_type;

	vmrc_top_type state;
	vmrc_top_type next_state;
	logic [2:0]   rst_req;
	logic [2:0]   irq_capable;

	// ==================================================================
	// Slow oscillator edge to one-cycle tick
	always_comb begin
		next_state.osc_prev = slow_osc_clock;
		next_state.tick = slow_osc_clock && !state.osc_prev && !slow_osc_stop;
	end

	always_ff @(posedge sys_clk) begin
		if (srst)
			state <= '0;
		else
			state <= next_state;
	end

	assign irq_capable = {1'b1, !REDUCED_MON1, 1'b0}; // RQ13

	// ==================================================================
	// Channels
	generate
		for (genvar i = 0; i < VMRC_MONITORS; i++) begin : g_mon
			vmrc_monitor vmrc_monitor_i (
				.sys_clk       (sys_clk),
				.srst          (srst),
				.flag_rst      (flag_rst),
				.detector_on   (detector_on[i]),
				.action_en     (action_en[i] && detector_on[i]),
				.filter_bypass (filter_bypass[i]),
				.action_sel    (action_sel[i]),
				.edge_sel      (edge_sel[i]),
				.sample_div    (sample_div[2*i +: 2]), // RQ9
				.flag_clear    (flag_clear[i]),
				.irq_capable   (irq_capable[i]),
				.settle_cycles (SETTLE_CYCLES),
				.slow_osc_tick (state.tick),
				.slow_osc_run  (!slow_osc_stop),
				.comparator    (comparator[i]),
				.cross_flag    (cross_flag[i]),
				.level         (level[i]),
				.irq           (irq[i]),
				.rst_req       (rst_req[i])
			);
		end
	endgenerate

	assign reset_out = |rst_req; // RQ4
endmodule

// [vmrc_chk.sv]
// Assertion checker for the voltage monitor controller ports
`timescale 1ns/1ps
module vmrc_chk (
	// Clock and resets
	input wire logic       sys_clk,
	input wire logic       srst,
	input wire logic       flag_rst,
	// Controls
	input wire logic [2:0] detector_on,
	input wire logic [2:0] action_en,
	input wire logic [2:0] filter_bypass,
	input wire logic [2:0] action_sel,
	input wire logic [2:0] edge_sel,
	input wire logic [5:0] sample_div,
	input wire logic [2:0] flag_clear,
	input wire logic       slow_osc_clock,
	input wire logic       slow_osc_stop,
	input wire logic [2:0] comparator,
	// Results
	input wire logic [2:0] cross_flag,
	input wire logic [2:0] level,
	input wire logic [2:0] irq,
	input wire logic       reset_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	// ==================================================================
	// Assertions
	a_irq0_never: assert property (irq[0] == 1'h0)
		else $error("interrupt from monitor 0");
	a_irq_pulse: assert property (irq[2] |=> !irq[2])
		else $error("interrupt longer than one cycle");
	a_irq_cause: assert property (irq[1] |-> $past(action_en[1]))
		else $error("interrupt without action enable");
	a_irq_mode: assert property (irq[2] |-> !$past(action_sel[2]))
		else $error("interrupt in reset mode");
	a_irq_flag: assert property (irq[2] |-> cross_flag[2])
		else $error("interrupt without crossing flag");
	a_reset_hold: assert property (reset_out |=> reset_out)
		else $error("reset request dropped");
	a_reset_cause: assert property ($rose(reset_out)
		|-> $past(|(action_en & (action_sel | 3'h1))))
		else $error("reset request without reset mode");
	a_flag_keep: assert property (disable iff (flag_rst)
		$fell(cross_flag[0]) |-> $past(flag_clear[0] || flag_rst))
		else $error("crossing flag lost");
	a_level_track: assert property (detector_on[2] ##1 (detector_on[2]
		&& filter_bypass[2]) |=> level[2] == $past(comparator[2]))
		else $error("bypass level not following comparator");
	a_off_level: assert property (!detector_on[1] [*3] |-> level[1])
		else $error("level low while detector off");

	// Main scenarios
	c_irq: cover property (irq[2]);
	c_reset: cover property ($rose(reset_out));
	c_flag: cover property ($rose(cross_flag[1]));
endmodule

bind vmrc_ctrl vmrc_chk vmrc_chk_i (.*);

// [test_vmrc_ctrl.sv]
// Self-checking testbench of the voltage monitor controller
`timescale 1ns/1ps
module test_vmrc_ctrl;
	logic       sys_clk = 1'h0, srst = 1'h1, flag_rst = 1'h1;
	logic [2:0] detector_on = 3'h0, action_en = 3'h0, flag_clear = 3'h0;
	logic [2:0] filter_bypass = 3'h0, action_sel = 3'h0, edge_sel = 3'h0;
	logic [2:0] comparator = 3'h7, cross_flag, level, irq;
	logic [5:0] sample_div = 6'h0;
	logic       slow_osc_clock = 1'h0, slow_osc_stop = 1'h1, reset_out;
	logic [1:0] code;
	logic [2:0] exp_q[$];
	int         n_mismatch = 0, check_count = 0, cycles = 0, p;

	vmrc_ctrl #(.SETTLE_CYCLES(16'h0004)) vmrc_ctrl_i (
		.sys_clk(sys_clk), .srst(srst), .flag_rst(flag_rst),
		.detector_on(detector_on), .action_en(action_en),
		.filter_bypass(filter_bypass), .action_sel(action_sel),
		.edge_sel(edge_sel), .sample_div(sample_div), .flag_clear(flag_clear),
		.slow_osc_clock(slow_osc_clock), .slow_osc_stop(slow_osc_stop),
		.comparator(comparator), .cross_flag(cross_flag), .level(level),
		.irq(irq), .reset_out(reset_out));

	// ==================================================================
	// Clocks, timeout and interrupt watcher
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) slow_osc_clock <= ~slow_osc_clock;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	always @(negedge sys_clk) begin
		if (!srst && irq !== 3'h0) begin
			if (exp_q.size() == 0) chk({1'h0, irq}, 4'h0);
			else chk({1'h0, irq}, {1'h0, exp_q.pop_front()});
		end
	end

	// ==================================================================
	// Tasks
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic clr(input int i);
		flag_clear[i] = 1'h1;
		tick(1);
		flag_clear[i] = 1'h0;
		tick(1);
	endtask
	task automatic arm(input int i, input logic byp, sel, edg);
		detector_on[i] = 1'h1;
		tick(8 + $urandom_range(0, 3));
		filter_bypass[i] = byp;
		action_sel[i] = sel;
		edge_sel[i] = edg;
		slow_osc_stop = byp;
		clr(i);
		tick(byp ? 1 : (8 << sample_div[2*i +: 2]) + 2);
		action_en[i] = 1'h1;
		tick(1);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ==================================================================
	// Scenarios
	initial begin
		p = $urandom(32'h934e435f);
		tick(16);
		srst = 1'h0;
		flag_rst = 1'h0;
		chk({reset_out, level}, 4'h7);
		arm(2, 1'h1, 1'h0, 1'h1);
		exp_q.push_back(3'h4);
		comparator[2] = 1'h0;
		tick(2);
		chk({1'h0, cross_flag}, 4'h4);
		comparator[2] = 1'h1;
		tick(3);
		clr(2);
		chk({1'h0, cross_flag}, 4'h0);
		$display("bypass falling test done");
		arm(1, 1'h1, 1'h0, 1'h0);
		comparator[1] = 1'h0;
		tick(3);
		chk({1'h0, cross_flag}, 4'h0);
		exp_q.push_back(3'h2);
		comparator[1] = 1'h1;
		tick(2);
		chk({1'h0, cross_flag}, 4'h2);
		action_en[1] = 1'h0;
		clr(1);
		comparator[1] = 1'h0;
		tick(2);
		comparator[1] = 1'h1;
		tick(2);
		chk({1'h0, cross_flag}, 4'h2);
		$display("bypass rising test done");
		arm(0, 1'h1, 1'h1, 1'h1);
		comparator[0] = 1'h0;
		tick(2);
		chk({reset_out, cross_flag}, 4'hb);
		detector_on = 3'h0;
		action_en = 3'h0;
		comparator[0] = 1'h1;
		srst = 1'h1;
		tick(1);
		srst = 1'h0;
		tick(1);
		chk({reset_out, cross_flag}, 4'h3);
		flag_rst = 1'h1;
		tick(1);
		flag_rst = 1'h0;
		tick(1);
		chk({reset_out, cross_flag}, 4'h0);
		$display("monitor 0 reset test done");
		arm(1, 1'h1, 1'h1, 1'h1);
		comparator[1] = 1'h0;
		tick(2);
		chk({reset_out, cross_flag}, 4'ha);
		detector_on[1] = 1'h0;
		action_en[1] = 1'h0;
		clr(1);
		srst = 1'h1;
		tick(1);
		srst = 1'h0;
		tick(1);
		chk({reset_out, cross_flag}, 4'h0);
		$display("monitor 1 reset test done");
		code = 2'($urandom);
		sample_div[5:4] = code;
		arm(2, 1'h0, 1'h0, 1'h0);
		for (int k = 0; k < 4; k++) begin
			action_en[2] = 1'h0;
			sample_div[5:4] = code;
			tick(12);
			action_en[2] = 1'h1;
			p = 2 << code;
			exp_q.push_back(3'h4);
			comparator[2] = ~comparator[2];
			tick(2 * p - 2);
			chk({1'h0, cross_flag}, 4'h0);
			tick(2 * p + 8);
			chk({1'h0, cross_flag}, 4'h4);
			chk({3'h0, level[2]}, {3'h0, comparator[2]});
			clr(2);
			code = code + 2'h1;
		end
		slow_osc_stop = 1'h1;
		comparator[2] = ~comparator[2];
		tick(40);
		chk({1'h0, cross_flag}, 4'h0);
		chk(4'(exp_q.size()), 4'h0);
		$display("filtered test done");
		conclude();
	end
endmodule
